// ### halfword_store_execution_tb.sv
/*
 * Self-checking bench for the half-word store unit: table of stores issued
 * back to back, then reset cases. Assumes the package and the memory model.
 */
`timescale 1ns/10ps
`default_nettype none

module halfword_store_execution_tb;
    // ==========================================================================
    // Signals and table.
    // ==========================================================================
    typedef struct packed {
        logic [2:0] ctl;
        logic [2:0] m;
        logic [2:0] ps;
        logic [2:0] p2s;
        logic [31:0] p;
        logic [31:0] len;
        logic [15:0] off;
        logic [5:0] fl;
        logic [31:0] addr;
        logic [31:0] val;
    } hws_row_t;
    localparam logic [31:0] DATA = 32'hA5C3_5A3C;
    logic clk, rst_n, issue_valid, upper_sel, use_index, parallel_req;
    hws_pkg::hws_mode_t mode;
    logic [2:0] ptr_sel, ptr2_sel;
    logic [31:0] ptr_value, len_value;
    logic [15:0] off;
    logic mem_wr_ff, misalign_exc_ff, illegal_ff, upd_idx_ff, upd_ptr_ff, done_ff, odd_seen;
    logic [31:0] mem_addr_ff, upd_value_ff;
    logic [15:0] mem_wdata_ff, wr_count, last_data;
    logic [1:0] upd_idx_sel_ff;
    logic [2:0] upd_ptr_sel_ff;
    wire logic [5:0] flags;
    int n_errors = 0;
    int n_tests = 0;
    int wrs = 0;
    // Control field is {upper, index source, paired}; flags are
    // {write, misaligned, illegal, index update, pointer update, done}.
    localparam int N_ROWS = 21;
    hws_row_t rows [N_ROWS] = '{
    '{3'h0, 3'h1, 3'h1, 3'h2, 32'h0000_0100, 32'h0, 16'h0, 6'h23, 32'h0000_0100, 32'h0000_0102},
    '{3'h0, 3'h2, 3'h1, 3'h2, 32'h0000_0100, 32'h0, 16'h0, 6'h23, 32'h0000_0100, 32'h0000_00FE},
    '{3'h6, 3'h1, 3'h1, 3'h2, 32'h0000_1010, 32'h0, 16'h0, 6'h25, 32'h0000_1010, 32'h0000_1012},
    '{3'h6, 3'h2, 3'h1, 3'h2, 32'h0000_1010, 32'h0, 16'h0, 6'h25, 32'h0000_1010, 32'h0000_100E},
    '{3'h0, 3'h3, 3'h1, 3'h2, 32'h0000_0200, 32'h0, 16'h001E, 6'h21, 32'h0000_021E, 32'h0},
    '{3'h0, 3'h4, 3'h1, 3'h2, 32'h0000_0200, 32'h0, 16'hFFFE, 6'h21, 32'h0001_01FE, 32'h0},
    '{3'h0, 3'h5, 3'h1, 3'h2, 32'h0002_0000, 32'h0, 16'hFFFE, 6'h21, 32'h0001_0002, 32'h0},
    '{3'h0, 3'h6, 3'h1, 3'h2, 32'h0000_0300, 32'h0, 16'h0, 6'h23, 32'h0000_0300, 32'h0000_0340},
    '{3'h4, 3'h6, 3'h1, 3'h1, 32'h0000_0300, 32'h0, 16'h0, 6'h21, 32'h0000_0300, 32'h0},
    '{3'h4, 3'h0, 3'h7, 3'h2, 32'h0000_0401, 32'h0, 16'h0, 6'h11, 32'h0, 32'h0},
    '{3'h4, 3'h1, 3'h1, 3'h2, 32'h0000_0400, 32'h0, 16'h0, 6'h08, 32'h0, 32'h0},
    '{3'h1, 3'h4, 3'h1, 3'h2, 32'h0000_0400, 32'h0, 16'h0002, 6'h08, 32'h0, 32'h0},
    '{3'h5, 3'h0, 3'h6, 3'h2, 32'h0000_0400, 32'h0, 16'h0, 6'h21, 32'h0000_0400, 32'h0},
    '{3'h2, 3'h6, 3'h1, 3'h2, 32'h0000_1010, 32'h0, 16'h0, 6'h25, 32'h0000_1010, 32'h0000_1050},
    '{3'h0, 3'h1, 3'h3, 3'h2, 32'h0000_0103, 32'h0, 16'h0, 6'h11, 32'h0, 32'h0},
    '{3'h0, 3'h4, 3'h1, 3'h2, 32'h0000_0201, 32'h0, 16'h0002, 6'h11, 32'h0, 32'h0},
    '{3'h4, 3'h3, 3'h1, 3'h2, 32'h0000_0400, 32'h0, 16'h0002, 6'h08, 32'h0, 32'h0},
    '{3'h2, 3'h3, 3'h1, 3'h2, 32'h0000_0400, 32'h0, 16'h0002, 6'h08, 32'h0, 32'h0},
    '{3'h2, 3'h0, 3'h1, 3'h2, 32'h0000_0500, 32'h0, 16'h0, 6'h21, 32'h0000_0500, 32'h0},
    '{3'h6, 3'h1, 3'h1, 3'h2, 32'h0000_100E, 32'h10, 16'h0, 6'h25, 32'h0000_100E, 32'h0000_1000},
    '{3'h2, 3'h2, 3'h1, 3'h2, 32'h0000_1000, 32'h10, 16'h0, 6'h25, 32'h0000_1000, 32'h0000_100E}
    };
    assign flags = {mem_wr_ff, misalign_exc_ff, illegal_ff, upd_idx_ff, upd_ptr_ff, done_ff};

    // Clock at 20 MHz.
    always #25 clk = ~clk;

    hws_store_unit i_dut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .upper_sel(upper_sel), .use_index(use_index), .mode(mode), .parallel_req(parallel_req),
        .data_value(DATA), .idx_sel(2'h2), .idx_value(ptr_value), .mod_value(32'h0000_0040),
        .len_value(len_value), .base_value(32'h0000_1000), .ptr_sel(ptr_sel),
        .ptr2_sel(ptr2_sel), .ptr_value(ptr_value), .ptr2_value(32'h0000_0040),
        .short_halfword_offset(off[4:0]), .long_halfword_offset(off), .mem_wr_ff(mem_wr_ff),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .misalign_exc_ff(misalign_exc_ff),
        .illegal_ff(illegal_ff), .upd_idx_ff(upd_idx_ff), .upd_idx_sel_ff(upd_idx_sel_ff),
        .upd_ptr_ff(upd_ptr_ff), .upd_ptr_sel_ff(upd_ptr_sel_ff), .upd_value_ff(upd_value_ff),
        .done_ff(done_ff));

    hws_mem_model i_mem (.clk(clk), .rst_n(rst_n), .wr(mem_wr_ff), .addr(mem_addr_ff),
        .wdata(mem_wdata_ff), .wr_count(wr_count), .odd_seen(odd_seen), .last_data(last_data));

    // ==========================================================================
    // Tasks.
    // ==========================================================================
    // Compares one value and counts the outcome.
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Puts one table row on the inputs.
    task automatic drive(input hws_row_t r);
        {upper_sel, use_index, parallel_req} = r.ctl;
        mode = hws_pkg::hws_mode_t'(r.m);
        ptr_sel = r.ps;
        ptr2_sel = r.p2s;
        ptr_value = r.p;
        len_value = r.len;
        off = r.off;
    endtask

    // Checks the answer to one row, one cycle after it was taken.
    task automatic check(input hws_row_t r);
        chk_w("flags", 32'(r.fl), 32'(flags));
        if (r.fl[5]) begin
            wrs++;
            chk_w("addr", r.addr, mem_addr_ff);
            chk_w("wdata", r.ctl[2] ? 32'(DATA[31:16]) : 32'(DATA[15:0]), 32'(mem_wdata_ff));
        end
        if (r.fl[2] | r.fl[1]) chk_w("upd", r.val, upd_value_ff);
        if (r.fl[1]) chk_w("psel", 32'(r.ps), 32'(upd_ptr_sel_ff));
        if (r.fl[2]) chk_w("isel", 32'h0000_0002, 32'(upd_idx_sel_ff));
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================================
    // Sequence.
    // ==========================================================================
    // Cuts a hang short after a bounded number of cycles.
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    // Reset, table issued back to back, then a reset in mid-store.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        issue_valid = 1'b0;
        drive(rows[0]);
        repeat (8) @(negedge clk);
        chk_w("rst_flags", 32'h0000_0000, 32'(flags));
        rst_n = 1'b1;
        for (int k = 0; k <= N_ROWS; k++) begin
            @(negedge clk);
            if (k > 0) check(rows[k-1]);
            if (k < N_ROWS) drive(rows[k]);
            issue_valid = (k < N_ROWS);
        end
        @(negedge clk);
        chk_w("idle_flags", 32'h0000_0000, 32'(flags));
        chk_w("wr_count", 32'(wrs), 32'(wr_count));
        chk_w("odd_write", 32'h0000_0000, 32'(odd_seen));
        chk_w("last_data", 32'(DATA[15:0]), 32'(last_data));
        // Reset lands while the answer to a store still stands.
        drive(rows[0]);
        issue_valid = 1'b1;
        @(negedge clk);
        chk_w("pre_rst_flags", 32'(rows[0].fl), 32'(flags));
        rst_n = 1'b0;
        @(negedge clk);
        chk_w("mid_rst_flags", 32'h0000_0000, 32'(flags));
        issue_valid = 1'b0;
        rst_n = 1'b1;
        @(negedge clk);
        chk_w("post_rst_flags", 32'h0000_0000, 32'(flags));
        drive(rows[1]);
        issue_valid = 1'b1;
        @(negedge clk);
        issue_valid = 1'b0;
        check(rows[1]);
        end_sim();
    end
endmodule

`default_nettype wire

// ### hws_mem_model.sv
/*
 * Behavioural model of core data memory behind the half-word store unit.
 * Assumes one registered write strobe per store on the unit's clock.
 */
`timescale 1ns/10ps
`default_nettype none

module hws_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] wr_count,
    output logic odd_seen,
    output logic [15:0] last_data
);
    // ==========================================================================
    // Write acceptance.
    // ==========================================================================
    // Counts writes, keeps the last half-word and flags any odd address.
    // Each write fills only half of the 32-bit data path; streams suit word stores.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_count <= 16'h0000;
            odd_seen <= 1'b0;
            last_data <= 16'h0000;
        end else if (wr) begin
            wr_count <= wr_count + 16'h0001;
            last_data <= wdata;
            if (addr[0]) begin
                odd_seen <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### hws_pkg.sv
/*
 * Package for the half-word store execution block: address mode and
 * operation encodings, register file sizes, field widths and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hws_pkg;

    // ==========================================================================
    // Operation and address mode encodings.
    // ==========================================================================
    // Address mode of the store.
    typedef enum logic [2:0] {
        HWS_AM_PLAIN = 3'h0, // Store at the pointer, no update.
        HWS_AM_INC = 3'h1, // Store, then add two bytes.
        HWS_AM_DEC = 3'h2, // Store, then subtract two bytes.
        HWS_AM_SHORT = 3'h3, // Pointer plus short even offset.
        HWS_AM_LONG_ADD = 3'h4, // Pointer plus long even offset.
        HWS_AM_LONG_SUB = 3'h5, // Pointer minus long even offset.
        HWS_AM_INDEX = 3'h6 // Store, then add second register.
    } hws_mode_t;

    // Execution state, one-hot.
    typedef enum logic [1:0] {
        HWS_ST_IDLE = 2'b01,
        HWS_ST_DONE = 2'b10
    } hws_state_t;

    // ==========================================================================
    // Widths, steps and reset values.
    // ==========================================================================
    localparam int HWS_DATA_W = 32;
    localparam int HWS_HALF_W = 16;
    localparam int HWS_SHORT_W = 5;
    localparam int HWS_LONG_W = 16;
    localparam int HWS_NUM_IDX = 4;
    localparam int HWS_NUM_PTR = 8;
    localparam logic [31:0] HWS_HALF_STEP = 32'h0000_0002;
    localparam logic [31:0] HWS_ZERO_WORD = 32'h0000_0000;
    localparam logic [15:0] HWS_ZERO_HALF = 16'h0000;
    localparam logic [2:0] HWS_ZERO_SEL = 3'h0;

endpackage

// ### hws_store_unit.sv
/*
 * Half-word store execution unit. Takes one issued store per cycle, forms
 * the effective address, drives a 16-bit memory write, reports misalignment
 * and hands back the updated pointer or index value. A refused or misaligned
 * store leaves memory and every pointer untouched; only a pulse reports it.
 * The checks at the end run on the core clock and rest during reset.
 * Assumes the sequencer supplies register contents and writes the updated
 * pointer back, and the memory accepts one write per cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module hws_store_unit #(
    parameter int IDX_CNT = hws_pkg::HWS_NUM_IDX
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic upper_sel,
    input wire logic use_index,
    input wire hws_pkg::hws_mode_t mode,
    input wire logic parallel_req,
    input wire logic [31:0] data_value,
    input wire logic [1:0] idx_sel,
    input wire logic [31:0] idx_value,
    input wire logic [31:0] mod_value,
    input wire logic [31:0] len_value,
    input wire logic [31:0] base_value,
    input wire logic [2:0] ptr_sel,
    input wire logic [2:0] ptr2_sel,
    input wire logic [31:0] ptr_value,
    input wire logic [31:0] ptr2_value,
    input wire logic [4:0] short_halfword_offset,
    input wire logic [15:0] long_halfword_offset,
    output logic mem_wr_ff,
    output logic [31:0] mem_addr_ff,
    output logic [15:0] mem_wdata_ff,
    output logic misalign_exc_ff,
    output logic illegal_ff,
    output logic upd_idx_ff,
    output logic [1:0] upd_idx_sel_ff,
    output logic upd_ptr_ff,
    output logic [2:0] upd_ptr_sel_ff,
    output logic [31:0] upd_value_ff,
    output logic done_ff
);

    // ==========================================================================
    // Decode of the issued store.
    // ==========================================================================
    // Combinational decode; every value below except state_ff settles within the issue cycle.
    logic [31:0] base_addr;
    logic [31:0] eff_addr;
    logic [31:0] step;
    logic [31:0] linear_next;
    logic [31:0] circ_next;
    logic [31:0] end_addr;
    logic [31:0] upd_next;
    logic form_ok;
    logic is_long;
    logic updates;
    logic odd_addr;
    logic go;
    hws_pkg::hws_state_t state_ff;

    // Source address selection and effective address forming.
    always_comb begin
        base_addr = use_index ? idx_value : ptr_value;
        is_long = (mode == hws_pkg::HWS_AM_LONG_ADD) || (mode == hws_pkg::HWS_AM_LONG_SUB);
        // Offsets are zero-extended byte counts; the sequencer keeps them even.
        case (mode)
            hws_pkg::HWS_AM_SHORT: begin
                eff_addr = base_addr + {27'h000_0000, short_halfword_offset};
            end
            hws_pkg::HWS_AM_LONG_ADD: begin
                eff_addr = base_addr + {16'h0000, long_halfword_offset};
            end
            hws_pkg::HWS_AM_LONG_SUB: begin
                eff_addr = base_addr - {16'h0000, long_halfword_offset};
            end
            default: begin
                eff_addr = base_addr;
            end
        endcase
    end

    // Legal form check: high stores only plain, index-register step, or index form.
    always_comb begin
        if (upper_sel) begin
            case (mode)
                hws_pkg::HWS_AM_PLAIN: form_ok = 1'b1;
                hws_pkg::HWS_AM_INC: form_ok = use_index;
                hws_pkg::HWS_AM_DEC: form_ok = use_index;
                // On an index register the index form steps by the modify value.
                hws_pkg::HWS_AM_INDEX: form_ok = 1'b1;
                default: form_ok = 1'b0;
            endcase
        end else begin
            case (mode)
                hws_pkg::HWS_AM_SHORT: form_ok = !use_index;
                hws_pkg::HWS_AM_LONG_ADD: form_ok = !use_index;
                hws_pkg::HWS_AM_LONG_SUB: form_ok = !use_index;
                // Plain, step and index forms are taken from either source.
                default: form_ok = 1'b1;
            endcase
        end
        // Long forms are 32-bit and cannot pair; every other form may.
        if (is_long && parallel_req) begin
            form_ok = 1'b0;
        end
    end

    // Pointer update value, with circular wrap on index registers.
    always_comb begin
        case (mode)
            hws_pkg::HWS_AM_INC: step = hws_pkg::HWS_HALF_STEP;
            hws_pkg::HWS_AM_DEC: step = hws_pkg::HWS_ZERO_WORD - hws_pkg::HWS_HALF_STEP;
            hws_pkg::HWS_AM_INDEX: step = use_index ? mod_value : ptr2_value;
            default: step = hws_pkg::HWS_ZERO_WORD;
        endcase
        linear_next = base_addr + step;
        // Base and length come from the sequencer's register file; no copy is held here,
        // so reset leaves them as they were and boot code must clear them.
        end_addr = base_value + len_value;
        circ_next = linear_next;
        // A zero length turns the wrap off, giving plain linear steps.
        if (len_value != hws_pkg::HWS_ZERO_WORD) begin
            if (!step[31] && (linear_next >= end_addr)) begin
                circ_next = linear_next - len_value;
            end else if (step[31] && (linear_next < base_value)) begin
                circ_next = linear_next + len_value;
            end
        end
        upd_next = use_index ? circ_next : linear_next;
        // An index form that names one pointer twice skips the increment.
        updates = (mode == hws_pkg::HWS_AM_INC) || (mode == hws_pkg::HWS_AM_DEC)
            || ((mode == hws_pkg::HWS_AM_INDEX) && (use_index || (ptr_sel != ptr2_sel)));
    end

    // Only bit 0 matters: a half-word needs two-byte alignment.
    assign odd_addr = eff_addr[0];
    assign go = issue_valid && form_ok;

    // ==========================================================================
    // Memory write and exception outputs.
    // ==========================================================================
    // Drives the half-word write, or the exception in its place.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_ff <= 1'b0;
            mem_addr_ff <= hws_pkg::HWS_ZERO_WORD;
            mem_wdata_ff <= hws_pkg::HWS_ZERO_HALF;
            misalign_exc_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else begin
            mem_wr_ff <= go && !odd_addr;
            // Address and data load every cycle; only the strobe qualifies them.
            mem_addr_ff <= eff_addr;
            mem_wdata_ff <= upper_sel ? data_value[31:16] : data_value[15:0];
            misalign_exc_ff <= go && odd_addr;
            illegal_ff <= issue_valid && !form_ok;
        end
    end

    // Write-back of the updated pointer or index; suppressed on exception.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_idx_ff <= 1'b0;
            upd_ptr_ff <= 1'b0;
            upd_idx_sel_ff <= 2'h0;
            upd_ptr_sel_ff <= hws_pkg::HWS_ZERO_SEL;
            upd_value_ff <= hws_pkg::HWS_ZERO_WORD;
        end else begin
            upd_idx_ff <= go && !odd_addr && updates && use_index;
            upd_ptr_ff <= go && !odd_addr && updates && !use_index;
            // Target and value load every cycle; the strobes alone qualify them.
            upd_idx_sel_ff <= idx_sel;
            upd_ptr_sel_ff <= ptr_sel;
            upd_value_ff <= upd_next;
        end
    end

    // Completion state: one cycle in DONE after each accepted store.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= hws_pkg::HWS_ST_IDLE;
            done_ff <= 1'b0;
        end else begin
            case (state_ff)
                hws_pkg::HWS_ST_IDLE: state_ff <= go ? hws_pkg::HWS_ST_DONE : hws_pkg::HWS_ST_IDLE;
                hws_pkg::HWS_ST_DONE: state_ff <= go ? hws_pkg::HWS_ST_DONE : hws_pkg::HWS_ST_IDLE;
                default: state_ff <= hws_pkg::HWS_ST_IDLE;
            endcase
            done_ff <= go;
        end
    end

    // ==========================================================================
    // Assertions and cover points.
    // ==========================================================================
    // Every check below runs on the core clock and rests while reset is low.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_HIGH_DATA: assert property (go && upper_sel && !odd_addr |=>
        mem_wr_ff && mem_wdata_ff == $past(data_value[31:16]))
        else $error("High half data wrong.");
    AST_LOW_DATA: assert property (go && !upper_sel && !odd_addr |=>
        mem_wdata_ff == $past(data_value[15:0]))
        else $error("Low half data wrong.");
    AST_ALIGN: assert property (mem_wr_ff |-> !mem_addr_ff[0])
        else $error("Write at odd address.");
    AST_MISALIGN: assert property (go && odd_addr |=> misalign_exc_ff && !mem_wr_ff)
        else $error("Misaligned store not trapped.");

    AST_STEP: assert property (go && !odd_addr && mode == hws_pkg::HWS_AM_INC && !use_index
        |=> upd_ptr_ff && upd_value_ff == $past(ptr_value) + 32'h0000_0002)
        else $error("Post-increment wrong.");
    AST_HIGH_STEP_PTR: assert property (issue_valid && upper_sel && !use_index
        && mode == hws_pkg::HWS_AM_DEC |=> illegal_ff && !mem_wr_ff)
        else $error("High store step on pointer accepted.");
    AST_SHORT: assert property (go && mode == hws_pkg::HWS_AM_SHORT && !odd_addr
        |=> mem_addr_ff == $past(ptr_value) + {27'h000_0000, $past(short_halfword_offset)})
        else $error("Short offset address wrong.");
    AST_LONG_SUB: assert property (go && mode == hws_pkg::HWS_AM_LONG_SUB
        |=> mem_addr_ff == $past(ptr_value) - {16'h0000, $past(long_halfword_offset)})
        else $error("Long offset address wrong.");

    AST_SAME_PTR: assert property (issue_valid && mode == hws_pkg::HWS_AM_INDEX && !use_index
        && ptr_sel == ptr2_sel |=> !upd_ptr_ff)
        else $error("Same-register index form updated.");
    AST_NO_PAIR: assert property (issue_valid && is_long && parallel_req |=> illegal_ff)
        else $error("Long form paired.");
    AST_EXC_NO_UPD: assert property (misalign_exc_ff |-> !upd_ptr_ff && !upd_idx_ff)
        else $error("Pointer updated on exception.");

    // Address forming and pointer update checks for the remaining forms, plus pairing, refusal and completion state checks.
    AST_LONG_ADD: assert property (go && mode == hws_pkg::HWS_AM_LONG_ADD
        |=> mem_addr_ff == $past(ptr_value) + {16'h0000, $past(long_halfword_offset)})
        else $error("Long offset add address wrong.");
    AST_DEC_PTR: assert property (go && !odd_addr && !use_index
        && mode == hws_pkg::HWS_AM_DEC
        |=> upd_ptr_ff && upd_value_ff == $past(ptr_value) - 32'h0000_0002)
        else $error("Post-decrement wrong.");
    AST_HIGH_INC_IDX: assert property (go && !odd_addr && upper_sel && use_index
        && mode == hws_pkg::HWS_AM_INC && len_value == 32'h0000_0000
        |=> upd_idx_ff && upd_value_ff == $past(idx_value) + 32'h0000_0002)
        else $error("High store index post-increment wrong.");
    AST_INDEX_ADD: assert property (go && !odd_addr && !use_index
        && mode == hws_pkg::HWS_AM_INDEX && ptr_sel != ptr2_sel
        |=> upd_ptr_ff && mem_addr_ff == $past(ptr_value)
        && upd_value_ff == $past(ptr_value) + $past(ptr2_value))
        else $error("Index form update wrong.");
    AST_PAIR_OK: assert property (issue_valid && upper_sel && parallel_req
        && mode == hws_pkg::HWS_AM_PLAIN |=> !illegal_ff && done_ff)
        else $error("Paired high store refused.");
    AST_CIRC_WRAP: assert property (go && !odd_addr && use_index
        && mode == hws_pkg::HWS_AM_INC && len_value != 32'h0000_0000
        && idx_value + 32'h0000_0002 == base_value + len_value
        |=> upd_idx_ff && upd_value_ff == $past(base_value))
        else $error("Circular wrap wrong.");
    AST_LINEAR_IDX: assert property (go && !odd_addr && use_index
        && mode == hws_pkg::HWS_AM_DEC && len_value == 32'h0000_0000
        |=> upd_idx_ff && upd_value_ff == $past(idx_value) - 32'h0000_0002)
        else $error("Linear index step wrong.");
    AST_IDX_SOURCE: assert property (go && use_index && mode == hws_pkg::HWS_AM_PLAIN
        |=> mem_addr_ff == $past(idx_value))
        else $error("Index source address wrong.");
    AST_REFUSED_QUIET: assert property (illegal_ff |-> !mem_wr_ff && !done_ff
        && !upd_ptr_ff && !upd_idx_ff && !misalign_exc_ff)
        else $error("Refused store had an effect.");
    AST_DONE_STATE: assert property (done_ff |-> state_ff == hws_pkg::HWS_ST_DONE)
        else $error("Completion state out of step.");

    // Cover points for the main store scenarios.
    COV_HIGH: cover property (go && upper_sel ##1 mem_wr_ff);
    COV_MISALIGN: cover property (misalign_exc_ff);
    COV_CIRC: cover property (go && use_index && len_value != 32'h0000_0000 ##1 upd_idx_ff);
    COV_INDEX: cover property (go && mode == hws_pkg::HWS_AM_INDEX ##1 upd_ptr_ff);
    COV_LONG: cover property (go && is_long ##1 mem_wr_ff);

endmodule

`default_nettype wire
